//--- logic/host_port_defs.svh
// Purpose: Shared constants for the host bus port and chip-select expander
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes: Offsets, codes and timing counts live here; types live in the package
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ****************************************
// Bus geometry
// ****************************************
`define HP_ADDR_W 11
`define HP_DATA_W 8
`define HP_NUM_EXP 5

// ****************************************
// Upper address decode codes
// ****************************************
`define HP_SEL_MASTER 3'h0
`define HP_SEL_RESVD 3'h6
`define HP_SEL_ALL 3'h7

// ****************************************
// Bus type strap codes
// ****************************************
`define HP_BT_ASYNC_A 3'h0
`define HP_BT_ASYNC_B 3'h1
`define HP_BT_SYNC 3'h7

// ****************************************
// Internal register layout
// ****************************************
`define HP_REG_GLOBAL_CFG 8'h00
`define HP_REG_ALARM_STAT 8'h01
`define HP_GIE_BIT 0
`define HP_CFG_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define HP_CLK_PERIOD_NS 10
`define HP_RESET_MIN_NS 10000
`define HP_RESET_CYCLES ((`HP_RESET_MIN_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)

`endif

//--- logic/host_port_pkg.sv
// Purpose: Types for the host bus port
// Assumes: Constants come from host_port_defs.svh
// Notes: No timescale; package only
package host_port_pkg;
  // Selected host bus style
  typedef enum logic [1:0] {
    BT_ASYNC_A,
    BT_ASYNC_B,
    BT_SYNC,
    BT_INVALID
  } bus_type_e;

  // Host-side access sequencer states
  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_STROBE,
    H_WAIT,
    H_DONE
  } host_state_e;
endpackage

//--- logic/host_port_if.sv
// Purpose: Pin-level link between host and the line interface device port
// Assumes: Data bus is resolved from both enables here
// Notes: Two-way data is carried as in, out and enable per party
`timescale 1ns/10ps
interface host_port_if;
  // Strobes and address
  logic cs_n;
  logic addr_latch_or_transfer_start;
  logic wr_strobe;
  logic rd_strobe;
  logic [10:0] addr;
  // Host side of the data bus
  logic [7:0] host_data_out;
  logic host_data_oe;
  // Device side of the data bus
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  // Handshake and interrupt
  logic access_done_ack;
  logic irq_n_oe;
  // Straps, reset and host clock
  logic [2:0] host_bus_type_sel;
  logic hw_reset_n;
  logic host_clk;

  // Resolved bus: device wins while it drives, else host while it drives; pulls high when neither drives
  wire [7:0] data_bus = dev_data_oe ? dev_data_out :
                        (host_data_oe ? host_data_out : 8'hff);
  // Open-drain interrupt with external pull-up
  wire irq_n = irq_n_oe ? 1'b0 : 1'b1;

  modport device (
    input cs_n, addr_latch_or_transfer_start, wr_strobe, rd_strobe, addr,
    input host_data_out, host_data_oe, host_bus_type_sel, hw_reset_n, host_clk,
    input data_bus,
    output dev_data_out, dev_data_oe, access_done_ack, irq_n_oe
  );

  modport host (
    output cs_n, addr_latch_or_transfer_start, wr_strobe, rd_strobe, addr,
    output host_data_out, host_data_oe, host_bus_type_sel, hw_reset_n, host_clk,
    input data_bus, dev_data_out, dev_data_oe, access_done_ack, irq_n
  );
endinterface

//--- logic/host_port_device.sv
// Purpose: Device end of the host bus port with chip-select expander
// Assumes: Host pins synchronous to clk; straps stable after reset
// Notes: Holds global config and sticky alarm status; alarms arrive as a vector
`timescale 1ns/10ps
`include "host_port_defs.svh"
module host_port_device #(
  parameter int RESET_CYCLES = `HP_RESET_CYCLES,
  parameter int NUM_ALARMS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host pins
  host_port_if.device bus,
  // User side: alarm levels and expander selects
  input wire logic [NUM_ALARMS-1:0] alarm_in,
  output logic [`HP_NUM_EXP-1:0] expander_select_n,
  output logic global_irq_enable,
  output logic [1:0] bus_style
);

  // ****************************************
  // Decode helpers
  // ****************************************
  // Strap code to bus style
  function automatic host_port_pkg::bus_type_e decode_type(input logic [2:0] c);
    case (c)
      `HP_BT_ASYNC_A: decode_type = host_port_pkg::BT_ASYNC_A;
      `HP_BT_ASYNC_B: decode_type = host_port_pkg::BT_ASYNC_B;
      `HP_BT_SYNC: decode_type = host_port_pkg::BT_SYNC;
      default: decode_type = host_port_pkg::BT_INVALID;
    endcase
  endfunction

  // Upper code hits the master device
  function automatic logic hits_master(input logic [2:0] c);
    hits_master = (c == `HP_SEL_MASTER) || (c == `HP_SEL_ALL);
  endfunction

  // ****************************************
  // Signals
  // ****************************************
  host_port_pkg::bus_type_e type_q; // Latched bus style
  logic [15:0] rst_cnt_q; // Width of hardware reset low
  logic hw_rst_q; // Defaults restore level, held until the reset pin rises
  logic [7:0] cfg_q; // Global configuration register
  logic [NUM_ALARMS-1:0] alarm_prev_q; // Last alarm levels
  logic [NUM_ALARMS-1:0] status_q; // Sticky alarm change status
  logic clk_prev_q; // Previous host clock sample
  logic strobe_prev_q; // Previous strobe activity
  logic [7:0] rd_data_q; // Read data register
  logic rd_oe_q; // Data drive enable
  logic ack_q; // Access acknowledge
  logic [7:0] reg_addr; // Internal register address
  logic [2:0] upper; // Chip select code
  logic selected; // Chip select asserted
  logic own; // Access targets own registers
  logic is_read; // Access direction read
  logic strobe; // Strobe active for the chosen style
  logic take; // Access is taken this cycle
  logic status_rd; // Status register read
  logic [NUM_ALARMS-1:0] change; // Alarm edges this cycle

  // ****************************************
  // Access decode
  // ****************************************
  assign upper = bus.addr[10:8];
  assign reg_addr = bus.addr[7:0];
  assign selected = !bus.cs_n;
  assign own = selected && hits_master(upper);

  // Strobe meaning per style
  always_comb begin
    is_read = 1'b0;
    strobe = 1'b0;
    case (type_q)
      host_port_pkg::BT_ASYNC_A: begin
        // Separate active-low read and write strobes
        is_read = !bus.rd_strobe;
        strobe = !bus.rd_strobe || !bus.wr_strobe;
      end
      host_port_pkg::BT_ASYNC_B: begin
        // Read/write level with active-low data strobe
        is_read = bus.wr_strobe;
        strobe = !bus.rd_strobe;
      end
      host_port_pkg::BT_SYNC: begin
        // Transfer start sampled on a rising host clock edge
        is_read = bus.wr_strobe;
        strobe = !bus.addr_latch_or_transfer_start && bus.host_clk && !clk_prev_q;
      end
      default: begin
        // Invalid strap: port stays dead
        is_read = 1'b0;
        strobe = 1'b0;
      end
    endcase
  end

  // Take on strobe leading edge; sync style uses the clock edge itself
  assign take = selected && strobe &&
                ((type_q == host_port_pkg::BT_SYNC) || !strobe_prev_q);
  assign status_rd = take && own && is_read && (reg_addr == `HP_REG_ALARM_STAT);
  assign change = alarm_in ^ alarm_prev_q;

  // ****************************************
  // Hardware reset filter
  // ****************************************
  // Reset pin must stay low longer than the minimum before defaults return
  always_ff @(posedge clk) begin
    if (sys_rst || bus.hw_reset_n) begin
      rst_cnt_q <= 16'h0000;
      hw_rst_q <= 1'b0;
    end else if (rst_cnt_q < 16'(RESET_CYCLES)) begin
      rst_cnt_q <= rst_cnt_q + 16'h0001;
      hw_rst_q <= 1'b0;
    end else begin
      hw_rst_q <= 1'b1;
    end
  end

  // ****************************************
  // Strap capture
  // ****************************************
  // Strap taken in clocked logic so reset never loads a port value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      type_q <= host_port_pkg::BT_INVALID;
    end else begin
      type_q <= decode_type(bus.host_bus_type_sel);
    end
  end

  // ****************************************
  // Edge history
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
      alarm_prev_q <= '0;
    end else begin
      clk_prev_q <= bus.host_clk;
      strobe_prev_q <= strobe;
      alarm_prev_q <= alarm_in;
    end
  end

  // ****************************************
  // Global configuration
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst || hw_rst_q) begin
      cfg_q <= `HP_CFG_RESET;
    end else if (take && own && !is_read && reg_addr == `HP_REG_GLOBAL_CFG) begin
      cfg_q <= bus.data_bus;
    end
  end
  assign global_irq_enable = cfg_q[`HP_GIE_BIT];

  // ****************************************
  // Alarm status and interrupt
  // ****************************************
  // New changes win over the clearing read so none is lost
  always_ff @(posedge clk) begin
    if (sys_rst || hw_rst_q) begin
      status_q <= '0;
    end else begin
      status_q <= (status_rd ? '0 : status_q) | change;
    end
  end
  assign bus.irq_n_oe = global_irq_enable && (|status_q);

  // ****************************************
  // Read data and drive
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_q <= 8'h00;
      rd_oe_q <= 1'b0;
    end else if (take && own && is_read) begin
      case (reg_addr)
        `HP_REG_GLOBAL_CFG: rd_data_q <= cfg_q;
        `HP_REG_ALARM_STAT: rd_data_q <= 8'(status_q);
        default: rd_data_q <= 8'h00;
      endcase
      rd_oe_q <= 1'b1;
    end else if (!selected || !strobe) begin
      rd_oe_q <= 1'b0;
    end
  end
  assign bus.dev_data_out = rd_data_q;
  assign bus.dev_data_oe = rd_oe_q && selected;

  // ****************************************
  // Acknowledge
  // ****************************************
  // Sync style: one-cycle pulse; async styles: held while strobe stays
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else if (take && own) begin
      ack_q <= 1'b1;
    end else if (type_q == host_port_pkg::BT_SYNC || !strobe || !selected) begin
      ack_q <= 1'b0;
    end
  end
  assign bus.access_done_ack = ack_q;

  // ****************************************
  // Chip-select expander
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `HP_NUM_EXP; g++) begin : g_exp
      // Active low select for companion g+1, or all on code 111
      assign expander_select_n[g] = !(selected &&
        ((upper == 3'(g + 1)) || (upper == `HP_SEL_ALL)));
    end
  endgenerate

  assign bus_style = type_q;
endmodule

//--- logic/host_port_host.sv
// Purpose: Host end driving the port for single register accesses
// Assumes: One request at a time; strap fixed by parameter
// Notes: Never issues reserved upper code 110
`timescale 1ns/10ps
`include "host_port_defs.svh"
module host_port_host #(
  parameter logic [2:0] BUS_TYPE = `HP_BT_ASYNC_A
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins
  host_port_if.host bus,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [10:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  // User answer
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic irq_pending
);

  // ****************************************
  // State
  // ****************************************
  host_port_pkg::host_state_e st_q;
  logic wr_q; // Latched direction
  logic [10:0] addr_q; // Latched address
  logic [7:0] wdata_q; // Latched write data
  logic [7:0] rdata_q; // Captured read data
  logic rsp_q; // Answer pulse
  logic hclk_q; // Host clock divider
  logic ack_wait; // Waiting on acknowledge

  // ****************************************
  // Sequencer
  // ****************************************
  // Reserved code 110 requests are dropped with an answer pulse; read data keeps its last value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= host_port_pkg::H_IDLE;
      wr_q <= 1'b0;
      addr_q <= 11'h000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      rsp_q <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      case (st_q)
        host_port_pkg::H_IDLE: begin
          if (req_valid && req_addr[10:8] != `HP_SEL_RESVD) begin
            wr_q <= req_write;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            st_q <= host_port_pkg::H_SETUP;
          end else if (req_valid) begin
            rsp_q <= 1'b1;
          end
        end
        host_port_pkg::H_SETUP: begin
          // Address settles one cycle before strobe; sync waits for low clock
          if (BUS_TYPE != `HP_BT_SYNC || !hclk_q) begin
            st_q <= host_port_pkg::H_STROBE;
          end
        end
        host_port_pkg::H_STROBE: begin
          st_q <= host_port_pkg::H_WAIT;
        end
        host_port_pkg::H_WAIT: begin
          if (bus.access_done_ack) begin
            rdata_q <= bus.data_bus;
            st_q <= host_port_pkg::H_DONE;
          end
        end
        host_port_pkg::H_DONE: begin
          rsp_q <= 1'b1;
          st_q <= host_port_pkg::H_IDLE;
        end
        default: begin
          st_q <= host_port_pkg::H_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Host clock for the synchronous style
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hclk_q <= 1'b0;
    end else begin
      hclk_q <= !hclk_q;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  assign ack_wait = (st_q == host_port_pkg::H_STROBE) || (st_q == host_port_pkg::H_WAIT);
  assign bus.host_clk = hclk_q;
  assign bus.host_bus_type_sel = BUS_TYPE;
  assign bus.hw_reset_n = !sys_rst;
  assign bus.cs_n = (st_q == host_port_pkg::H_IDLE);
  assign bus.addr = addr_q;
  assign bus.addr_latch_or_transfer_start = !(BUS_TYPE == `HP_BT_SYNC &&
                                              st_q == host_port_pkg::H_STROBE);
  // Async A: active-low read and write strobes; B and sync: direction level
  assign bus.wr_strobe = (BUS_TYPE == `HP_BT_ASYNC_A) ? !(ack_wait && wr_q) : !wr_q;
  assign bus.rd_strobe = (BUS_TYPE == `HP_BT_ASYNC_A) ? !(ack_wait && !wr_q) : !ack_wait;
  assign bus.host_data_out = wdata_q;
  assign bus.host_data_oe = wr_q && (st_q != host_port_pkg::H_IDLE);

  // ****************************************
  // User answer
  // ****************************************
  assign req_ready = (st_q == host_port_pkg::H_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign irq_pending = !bus.irq_n;
endmodule

//--- tb/host_port_checker.sv
// Purpose: Concurrent checks on the host/device link pins
// Assumes: Synchronous style between the two ends; one clk domain
// Notes: Instantiated beside the interface; sees pins only
`timescale 1ns/10ps
module host_port_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host-driven pins
  input wire logic cs_n,
  input wire logic addr_latch_or_transfer_start,
  input wire logic wr_strobe,
  input wire logic [10:0] addr,
  input wire logic host_data_oe,
  input wire logic [2:0] host_bus_type_sel,
  // Device-driven pins
  input wire logic dev_data_oe,
  input wire logic access_done_ack,
  input wire logic irq_n_oe
);
  // ****************************************
  // Helpers
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic own_code; // Upper code reaches this device
  logic rd_seen_q; // A config or status access since the interrupt rose
  assign own_code = (addr[10:8] == 3'h0) || (addr[10:8] == 3'h7);
  // Set has priority so a read in the same cycle as a new rise still counts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_seen_q <= 1'b0;
    end else if (!cs_n && access_done_ack && (addr[7:1] == 7'h00)) begin
      rd_seen_q <= 1'b1;
    end else if ($rose(irq_n_oe)) begin
      rd_seen_q <= 1'b0;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_oe_own_read: assert property (dev_data_oe && !$past(dev_data_oe) |->
    !cs_n && own_code && wr_strobe) else $error("data driven outside own read");
  a_idle_quiet: assert property (cs_n && $past(cs_n) |->
    !dev_data_oe && !access_done_ack) else $error("device active while deselected");
  a_ack_own: assert property ($rose(access_done_ack) |-> !cs_n && own_code)
    else $error("acknowledge for foreign code");
  a_ack_bound: assert property ($fell(addr_latch_or_transfer_start) && !cs_n && own_code
    |-> ##[1:8] access_done_ack) else $error("no acknowledge after transfer start");
  a_ack_single: assert property (access_done_ack |=> !access_done_ack)
    else $error("sync acknowledge longer than one cycle");
  // The clearing read still shows its acknowledge in the cycle the line lets go,
  // one edge before rd_seen_q can record it, so that cycle counts as well
  a_irq_release: assert property ($fell(irq_n_oe) |-> rd_seen_q ||
    (!cs_n && access_done_ack && (addr[7:1] == 7'h00)))
    else $error("interrupt released without status read");
  a_no_reserved: assert property (!cs_n |-> addr[10:8] != 3'h6)
    else $error("reserved upper code on bus");
  a_addr_hold: assert property (!cs_n && $past(!cs_n) |-> $stable(addr))
    else $error("address moved during access");
  a_no_clash: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data bus");
  a_strap_fixed: assert property ($stable(host_bus_type_sel))
    else $error("bus type strap changed");
  // Main scenarios
  c_read: cover property (!cs_n && dev_data_oe);
  c_irq_up: cover property ($rose(irq_n_oe));
  c_irq_down: cover property ($fell(irq_n_oe));
endmodule

//--- tb/host_bus_port_cs_expander_tb.sv
// Purpose: Self-checking bench for host end, device end and selects
// Assumes: Pair A runs synchronous style; pair B is bench-driven async A, then restrapped to async B
// Notes: Pair B lets the bench break rules the host end never breaks
`timescale 1ns/10ps
module host_bus_port_cs_expander_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk; // 100 MHz
  logic sys_rst; // Sync reset
  logic req_valid, req_write, req_ready, rsp_valid, irq_pending;
  logic [10:0] req_addr;
  logic [7:0] req_wdata, rsp_rdata, rd;
  logic [7:0] alarm_in; // Alarm levels into device A
  logic [7:0] alarm_b; // Alarm levels into device B
  logic [4:0] sel_a, sel_b, exp_sel;
  logic gie_a, gie_b;
  logic [1:0] style_a, style_b;
  int mismatches, n_tests, cyc;
  host_port_if bus_a ();
  host_port_if bus_b ();
  // ****************************************
  // Design ends and checker
  // ****************************************
  host_port_device #(.RESET_CYCLES(8)) u_host_port_device (.clk(clk),
    .sys_rst(sys_rst), .bus(bus_a), .alarm_in(alarm_in), .expander_select_n(sel_a),
    .global_irq_enable(gie_a), .bus_style(style_a));
  host_port_host #(.BUS_TYPE(3'h7)) u_host_port_host (.clk(clk), .sys_rst(sys_rst),
    .bus(bus_a), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .irq_pending(irq_pending));
  // Second device faces the bench so selects and reset can be driven directly
  host_port_device #(.RESET_CYCLES(8)) u_host_port_device_b (.clk(clk),
    .sys_rst(sys_rst), .bus(bus_b), .alarm_in(alarm_b), .expander_select_n(sel_b),
    .global_irq_enable(gie_b), .bus_style(style_b));
  host_port_checker u_host_port_checker (.clk(clk), .sys_rst(sys_rst), .cs_n(bus_a.cs_n),
    .addr_latch_or_transfer_start(bus_a.addr_latch_or_transfer_start),
    .wr_strobe(bus_a.wr_strobe), .addr(bus_a.addr), .host_data_oe(bus_a.host_data_oe),
    .host_bus_type_sel(bus_a.host_bus_type_sel), .dev_data_oe(bus_a.dev_data_oe),
    .access_done_ack(bus_a.access_done_ack), .irq_n_oe(bus_a.irq_n_oe));
  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Ceiling well above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One access through the host end; entered just after an edge
  task automatic hacc(input logic w, input logic [10:0] a, input logic [7:0] wd,
    output logic [7:0] r);
    int i;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = wd;
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) begin
      @(posedge clk); #1;
    end
    @(posedge clk); #1;
    req_valid = 1'b0;
    for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) begin
      @(posedge clk); #1;
    end
    chk("rsp_valid", {7'h00, rsp_valid}, 8'h01);
    r = rsp_rdata;
    @(posedge clk); #1;
  endtask
  // Async style A access on pair B; strobe held until acknowledge seen
  task automatic bacc(input logic w, input logic [10:0] a, input logic [7:0] wd,
    output logic [7:0] r);
    int i;
    bus_b.cs_n = 1'b0;
    bus_b.addr = a;
    bus_b.host_data_out = wd;
    bus_b.host_data_oe = w;
    @(posedge clk); #1;
    if (w) bus_b.wr_strobe = 1'b0;
    else bus_b.rd_strobe = 1'b0;
    i = 0;
    do begin
      @(posedge clk); #1;
      i++;
    end while (bus_b.access_done_ack !== 1'b1 && i < 20);
    chk("ack_b", {7'h00, bus_b.access_done_ack}, 8'h01);
    r = bus_b.data_bus;
    @(posedge clk); #1;
    bus_b.wr_strobe = 1'b1;
    bus_b.rd_strobe = 1'b1;
    bus_b.cs_n = 1'b1;
    bus_b.host_data_oe = 1'b0;
    @(posedge clk); #1;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mismatches = 0;
    n_tests = 0;
    cyc = 0;
    sys_rst = 1'b1;
    {req_valid, req_write, req_addr, req_wdata} = '0;
    alarm_in = 8'h00;
    alarm_b = 8'h00;
    {bus_b.cs_n, bus_b.addr_latch_or_transfer_start, bus_b.wr_strobe} = 3'b111;
    {bus_b.rd_strobe, bus_b.hw_reset_n, bus_b.host_clk} = 3'b110;
    {bus_b.addr, bus_b.host_data_out, bus_b.host_data_oe} = '0;
    bus_b.host_bus_type_sel = 3'h0;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge clk); #1;
    chk("style_a", {6'h00, style_a}, 8'h02);
    chk("style_b", {6'h00, style_b}, 8'h00);
    hacc(1'b0, 11'h000, 8'h00, rd);
    chk("cfg_default", rd, 8'h00);
    // Alarm change with interrupts disabled: status only
    alarm_in[2] = 1'b1;
    repeat (4) @(posedge clk); #1;
    chk("irq_off", {7'h00, irq_pending}, 8'h00);
    hacc(1'b0, 11'h001, 8'h00, rd);
    chk("status", rd, 8'h04);
    hacc(1'b1, 11'h000, 8'h01, rd);
    chk("gie_a", {7'h00, gie_a}, 8'h01);
    hacc(1'b0, 11'h700, 8'h00, rd);
    chk("all_code_read", rd, 8'h01);
    // Falling edge of the same alarm now raises the interrupt
    alarm_in[2] = 1'b0;
    repeat (4) @(posedge clk); #1;
    chk("irq_on", {7'h00, irq_pending}, 8'h01);
    hacc(1'b0, 11'h001, 8'h00, rd);
    chk("status2", rd, 8'h04);
    repeat (3) @(posedge clk); #1;
    chk("irq_clear", {7'h00, irq_pending}, 8'h00);
    hacc(1'b0, 11'h010, 8'h00, rd);
    chk("unused_reg", rd, 8'h00);
    hacc(1'b0, 11'h600, 8'h00, rd);
    chk("sel_a_idle", {3'h0, sel_a}, 8'h1f);
    // Every upper code on pair B, then deselected
    for (int c = 0; c < 8; c++) begin
      bus_b.addr = {c[2:0], 8'h00};
      bus_b.cs_n = 1'b0;
      @(posedge clk); #1;
      exp_sel = (c == 7) ? 5'h00 : ((c >= 1 && c <= 5) ? ~(5'h01 << (c - 1)) : 5'h1f);
      chk("sel_code", {3'h0, sel_b}, {3'h0, exp_sel});
    end
    bus_b.cs_n = 1'b1;
    bus_b.rd_strobe = 1'b0;
    repeat (3) @(posedge clk); #1;
    chk("sel_off", {3'h0, sel_b}, 8'h1f);
    chk("oe_off", {6'h00, bus_b.dev_data_oe, bus_b.access_done_ack}, 8'h00);
    bus_b.rd_strobe = 1'b1;
    @(posedge clk); #1;
    bacc(1'b1, 11'h000, 8'h01, rd);
    bacc(1'b0, 11'h000, 8'h00, rd);
    chk("cfg_b", rd, 8'h01);
    chk("oe_after", {7'h00, bus_b.dev_data_oe}, 8'h00);
    // Enabled device B raises its line on an alarm edge; long reset must drop it
    alarm_b = 8'h01;
    repeat (2) @(posedge clk); #1;
    chk("irq_b_on", {7'h00, bus_b.irq_n}, 8'h00);
    // Short hardware reset keeps settings, long one restores them
    bus_b.hw_reset_n = 1'b0;
    repeat (4) @(posedge clk); #1;
    chk("gie_short", {7'h00, gie_b}, 8'h01);
    repeat (12) @(posedge clk); #1;
    chk("gie_long", {7'h00, gie_b}, 8'h00);
    chk("irq_b_reset", {7'h00, bus_b.irq_n}, 8'h01);
    bus_b.hw_reset_n = 1'b1;
    @(posedge clk); #1;
    bacc(1'b0, 11'h000, 8'h00, rd);
    chk("cfg_b_reset", rd, 8'h00);
    // Restrap B to style B; a read keeps direction high and pulses the data strobe
    bus_b.host_bus_type_sel = 3'h1;
    alarm_b = 8'h03;
    repeat (2) @(posedge clk); #1;
    chk("style_b_b", {6'h00, style_b}, 8'h01);
    bacc(1'b0, 11'h001, 8'h00, rd);
    chk("status_b_b", rd, 8'h02);
    finish_test();
  end
endmodule
